// ### common/pfta_regs.svh
`ifndef PFTA_REGS_SVH
`define PFTA_REGS_SVH

// register file of the device end, word offsets in the device's own space
`define PFTA_OFF_LATCH   3'h0
`define PFTA_OFF_PTRL    3'h1
`define PFTA_OFF_PTRH    3'h2
`define PFTA_OFF_PTRU    3'h3
`define PFTA_OFF_MEMCTL  3'h4
`define PFTA_OFF_UNLOCK  3'h5

// memory control register fields
`define PFTA_BIT_PROG    7
`define PFTA_BIT_CFG     6
`define PFTA_BIT_ERASE   4
`define PFTA_BIT_WERR    3
`define PFTA_BIT_WEN     2
`define PFTA_BIT_START   1

`define PFTA_UNLOCK_1    8'h55
`define PFTA_UNLOCK_2    8'haa

// holding registers come out of reset erased
`define PFTA_HOLD_RESET  8'hff

// programming timer: 2 ms at 100 MHz
`define PFTA_PROG_TIME_US 2000
`define PFTA_CLK_MHZ      100
`define PFTA_PROG_CYCLES  (`PFTA_PROG_TIME_US * `PFTA_CLK_MHZ)

// controller register map on apb, byte addresses
`define PFTA_APB_CMD     12'h000
`define PFTA_APB_WDATA   12'h004
`define PFTA_APB_STATUS  12'h008
`define PFTA_APB_RDATA   12'h00c

`endif

// ### common/pfta_pkg.sv
package pfta_pkg;
  typedef enum logic [1:0] {
    PFTA_PTR_KEEP,
    PFTA_PTR_POSTINC,
    PFTA_PTR_POSTDEC,
    PFTA_PTR_PREINC
  } pfta_ptrmode_e;

  typedef enum logic [1:0] {
    PFTA_OP_REGWR,
    PFTA_OP_REGRD,
    PFTA_OP_TABLE_READ_OP,
    PFTA_OP_TABLE_WRITE_OP
  } pfta_op_e;
endpackage

// ### common/pfta_if.sv
`timescale 1ns/1ns
interface pfta_if;
  import pfta_pkg::*;
  logic          reqValid;
  pfta_op_e      reqOp;
  pfta_ptrmode_e reqMode;
  logic [2:0]    reqAddr;
  logic [7:0]    reqData;
  logic          reqReady;
  logic          rspValid;
  logic [7:0]    rspData;
  logic          stall;
  logic [20:0]   memAddr;
  logic [15:0]   memWord;
  logic          flashWrite;
  logic          flashErase;
  logic [18:0]   flashBlock;
  logic [63:0]   flashData;
  logic          flashBusy;
  logic          interrupted;

  modport dev (
    input  reqValid, reqOp, reqMode, reqAddr, reqData, memWord, interrupted,
    output reqReady, rspValid, rspData, stall, memAddr,
    output flashWrite, flashErase, flashBlock, flashData, flashBusy
  );
  modport host (
    output reqValid, reqOp, reqMode, reqAddr, reqData, memWord, interrupted,
    input  reqReady, rspValid, rspData, stall, memAddr,
    input  flashWrite, flashErase, flashBlock, flashData, flashBusy
  );
endinterface

// ### logic/pfta_device.sv
`timescale 1ns/1ns
`include "pfta_regs.svh"
// Notes on behaviour
// - single 8-bit transfer latch, software visible
// - 22-bit pointer from three byte registers
// - auto updates touch only low 21 bits
// - four pointer modes per table op
// - table read uses all 22 pointer bits
// - table write fills holding register, not array
// - program 8-byte block by pointer bits 21:3
// - row erase uses pointer bits 21:6
// - pointer bit 0 selects word byte
// - erase unit is 32 words
// - erase bit in the start write makes that start an erase
// - software clears config select first
// - start only after 55h then aah unlock
// - erase stalls execution about 2 ms
// - programming always long write, stalls execution
// - program unit is 4 words
// - software fills eight holding registers first
// - software writes control to launch program
// - software places a nop after start
// - hardware clears start at completion
// - hardware clears erase select after erase
// - reset during write sets error flag
// - write enable clear inhibits flash cycles
module pfta_device #(
  parameter int PROG_CYCLES = `PFTA_PROG_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  pfta_if.dev      bus
);
  import pfta_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  latch_reg;
  logic [21:0] ptr_reg;
  logic [7:0]  hold_reg [8];
  logic        progSel_reg, cfgSel_reg, eraseSel_reg, werr_reg, wen_reg;
  logic        start_reg;
  logic [1:0]  unlock_reg;
  logic        busy_reg, isErase_reg;
  logic [31:0] timer_reg;
  logic        rspValid_reg;
  logic [7:0]  rspData_reg;

  ////////////////////////////////////////////////////////////////////////
  wire         take     = bus.reqValid && bus.reqReady;
  wire         isRegWr  = take && bus.reqOp == PFTA_OP_REGWR;
  wire         isRegRd  = take && bus.reqOp == PFTA_OP_REGRD;
  wire         isTblRd  = take && bus.reqOp == PFTA_OP_TABLE_READ_OP;
  wire         isTblWt  = take && bus.reqOp == PFTA_OP_TABLE_WRITE_OP;
  wire         isTbl    = isTblRd || isTblWt;
  wire [20:0]  ptrInc   = ptr_reg[20:0] + 21'h000001;
  wire [20:0]  ptrDec   = ptr_reg[20:0] - 21'h000001;
  wire         preInc   = bus.reqMode == PFTA_PTR_PREINC;
  wire [21:0]  accPtr   = preInc ? {ptr_reg[21], ptrInc} : ptr_reg;
  wire [20:0]  postLow  = (bus.reqMode == PFTA_PTR_POSTINC || preInc) ? ptrInc :
                          (bus.reqMode == PFTA_PTR_POSTDEC) ? ptrDec : ptr_reg[20:0];
  wire         wrLatch  = isRegWr && bus.reqAddr == `PFTA_OFF_LATCH;
  wire         wrCtl    = isRegWr && bus.reqAddr == `PFTA_OFF_MEMCTL;
  wire         wrUnlock = isRegWr && bus.reqAddr == `PFTA_OFF_UNLOCK;
  wire         setStart = wrCtl && bus.reqData[`PFTA_BIT_START];
  // start honoured only when armed, enabled, program space
  wire         launch   = setStart && !start_reg && unlock_reg == 2'h2
                          && bus.reqData[`PFTA_BIT_WEN]
                          && bus.reqData[`PFTA_BIT_PROG];
  wire         done     = busy_reg && timer_reg == 32'h0;
  wire [7:0]   ctlRead  = {progSel_reg, cfgSel_reg, 1'b0, eraseSel_reg,
                           werr_reg, wen_reg, start_reg, 1'b0};

  assign bus.reqReady   = !busy_reg;
  assign bus.stall      = busy_reg;
  assign bus.flashBusy  = busy_reg;
  assign bus.rspValid   = rspValid_reg;
  assign bus.rspData    = rspData_reg;
  assign bus.memAddr    = accPtr[21:1];
  assign bus.flashWrite = done && !isErase_reg;
  assign bus.flashErase = done && isErase_reg;
  assign bus.flashBlock = isErase_reg ? {ptr_reg[21:6], 3'b000}
                                      : ptr_reg[21:3];
  assign bus.flashData  = {hold_reg[7], hold_reg[6], hold_reg[5], hold_reg[4],
                           hold_reg[3], hold_reg[2], hold_reg[1], hold_reg[0]};

  function automatic logic [7:0] regRead(input logic [2:0] a);
    unique case (a)
      `PFTA_OFF_LATCH:  regRead = latch_reg;
      `PFTA_OFF_PTRL:   regRead = ptr_reg[7:0];
      `PFTA_OFF_PTRH:   regRead = ptr_reg[15:8];
      `PFTA_OFF_PTRU:   regRead = {2'b00, ptr_reg[21:16]};
      `PFTA_OFF_MEMCTL: regRead = ctlRead;
      default:          regRead = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_reg <= 8'h00;
    end else if (isTblRd) begin
      latch_reg <= accPtr[0] ? bus.memWord[15:8] : bus.memWord[7:0];
    end else if (wrLatch) begin
      latch_reg <= bus.reqData;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ptr_reg <= 22'h000000;
    end else if (isTbl) begin
      ptr_reg <= {ptr_reg[21], postLow};
    end else if (isRegWr && bus.reqAddr == `PFTA_OFF_PTRL) begin
      ptr_reg[7:0] <= bus.reqData;
    end else if (isRegWr && bus.reqAddr == `PFTA_OFF_PTRH) begin
      ptr_reg[15:8] <= bus.reqData;
    end else if (isRegWr && bus.reqAddr == `PFTA_OFF_PTRU) begin
      ptr_reg[21:16] <= bus.reqData[5:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gHold
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          hold_reg[g] <= `PFTA_HOLD_RESET;
        end else if (isTblWt && accPtr[2:0] == 3'(g)) begin
          hold_reg[g] <= latch_reg;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      unlock_reg <= 2'h0;
    end else if (wrUnlock && bus.reqData == `PFTA_UNLOCK_1) begin
      unlock_reg <= 2'h1;
    end else if (wrUnlock && bus.reqData == `PFTA_UNLOCK_2 && unlock_reg == 2'h1) begin
      unlock_reg <= 2'h2;
    end else if (take) begin
      unlock_reg <= 2'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      progSel_reg  <= 1'b0;
      cfgSel_reg   <= 1'b0;
      eraseSel_reg <= 1'b0;
      wen_reg      <= 1'b0;
    end else if (wrCtl) begin
      progSel_reg  <= bus.reqData[`PFTA_BIT_PROG];
      cfgSel_reg   <= bus.reqData[`PFTA_BIT_CFG];
      eraseSel_reg <= bus.reqData[`PFTA_BIT_ERASE];
      wen_reg      <= bus.reqData[`PFTA_BIT_WEN];
    end else if (done && isErase_reg) begin
      eraseSel_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      werr_reg <= 1'b0;
    end else if (busy_reg && bus.interrupted) begin
      werr_reg <= 1'b1;
    end else if (wrCtl && !bus.reqData[`PFTA_BIT_WERR]) begin
      werr_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_reg    <= 1'b0;
      start_reg   <= 1'b0;
      isErase_reg <= 1'b0;
      timer_reg   <= 32'h0;
    end else if (launch) begin
      busy_reg    <= 1'b1;
      start_reg   <= 1'b1;
      isErase_reg <= bus.reqData[`PFTA_BIT_ERASE];
      timer_reg   <= 32'(PROG_CYCLES - 1);
    end else if (busy_reg && bus.interrupted) begin
      busy_reg    <= 1'b0;
      start_reg   <= 1'b0;
    end else if (done) begin
      busy_reg    <= 1'b0;
      start_reg   <= 1'b0;
    end else if (busy_reg) begin
      timer_reg   <= timer_reg - 32'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rspValid_reg <= 1'b0;
      rspData_reg  <= 8'h00;
    end else begin
      rspValid_reg <= isRegRd || isTblRd;
      rspData_reg  <= isTblRd ? (accPtr[0] ? bus.memWord[15:8] : bus.memWord[7:0])
                              : regRead(bus.reqAddr);
    end
  end
endmodule

// ### logic/pfta_host.sv
`timescale 1ns/1ns
`include "pfta_regs.svh"
module pfta_host (
  input  wire logic        clk,
  input  wire logic        nrst,
  pfta_if.host             bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] memWordIn,
  input  wire logic        resetHit
);
  import pfta_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] cmd_reg, wdata_reg;
  logic [7:0]  rdata_reg;
  logic        pend_reg;
  logic        got_reg;

  wire apbWr  = psel && penable && pwrite && pready;
  wire hitCmd = paddr == `PFTA_APB_CMD;
  wire known  = hitCmd || paddr == `PFTA_APB_WDATA ||
                paddr == `PFTA_APB_STATUS || paddr == `PFTA_APB_RDATA;

  // software keeps the unlock order, config clear and nop itself
  assign bus.reqValid    = pend_reg;
  assign bus.reqOp       = pfta_op_e'(cmd_reg[1:0]);
  assign bus.reqMode     = pfta_ptrmode_e'(cmd_reg[3:2]);
  assign bus.reqAddr     = cmd_reg[6:4];
  assign bus.reqData     = wdata_reg[7:0];
  assign bus.memWord     = memWordIn;
  assign bus.interrupted = resetHit;
  assign pready          = 1'b1;
  assign pslverr         = psel && penable && !known;
  assign prdata          = paddr == `PFTA_APB_STATUS ?
                           {28'h0, got_reg, bus.flashBusy, bus.stall, pend_reg} :
                           paddr == `PFTA_APB_RDATA ? {24'h0, rdata_reg} :
                           paddr == `PFTA_APB_CMD ? cmd_reg : wdata_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_reg   <= 32'h0;
      wdata_reg <= 32'h0;
      pend_reg  <= 1'b0;
    end else begin
      if (apbWr && paddr == `PFTA_APB_WDATA) wdata_reg <= pwdata;
      if (apbWr && hitCmd && !pend_reg) begin
        cmd_reg  <= pwdata;
        pend_reg <= 1'b1;
      end else if (bus.reqValid && bus.reqReady) begin
        pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
      got_reg   <= 1'b0;
    end else if (bus.rspValid) begin
      rdata_reg <= bus.rspData;
      got_reg   <= 1'b1;
    end else if (apbWr && hitCmd) begin
      got_reg   <= 1'b0;
    end
  end
endmodule

// ### sim/pfta_checker.sv
`timescale 1ns/1ns
`include "pfta_regs.svh"
module pfta_checker #(
  parameter int PROG_CYCLES = 8
) (
  input wire logic          clk,
  input wire logic          nrst,
  input wire logic          reqValid,
  input pfta_pkg::pfta_op_e reqOp,
  input wire logic [2:0]    reqAddr,
  input wire logic [7:0]    reqData,
  input wire logic          reqReady,
  input wire logic          rspValid,
  input wire logic          stall,
  input wire logic          flashWrite,
  input wire logic          flashErase,
  input wire logic [18:0]   flashBlock,
  input wire logic          flashBusy,
  input wire logic          interrupted
);
  import pfta_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  int unsigned stallCnt;
  logic        abortSeen;
  wire logic   rdHit = reqValid && reqReady
                       && (reqOp == PFTA_OP_REGRD || reqOp == PFTA_OP_TABLE_READ_OP);
  wire logic   startHit = reqValid && reqReady && reqOp == PFTA_OP_REGWR
                          && reqAddr == `PFTA_OFF_MEMCTL && reqData[`PFTA_BIT_START]
                          && reqData[`PFTA_BIT_WEN] && reqData[`PFTA_BIT_PROG];
  ////////////////////////////////////////////////////////////////
  // stall length and abort tracking
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stallCnt <= 0;
      abortSeen <= 1'b0;
    end else begin
      stallCnt <= stall ? stallCnt + 1 : 0;
      abortSeen <= interrupted || (abortSeen && stall);
    end
  end
  sequence s_pulse;
    flashWrite || flashErase;
  endsequence
  sequence s_last;
    stall ##1 !stall;
  endsequence
  sequence s_done;
    $fell(stall) && !abortSeen;
  endsequence
  ////////////////////////////////////////////////////////////////
  chk_read_answer: assert property (rdHit |=> rspValid)
    else $error("read taken without answer");
  chk_answer_cause: assert property (rspValid |-> $past(rdHit))
    else $error("answer without read");
  chk_busy_refuse: assert property (flashBusy |-> !reqReady && !rspValid)
    else $error("request accepted while busy");
  chk_start_cause: assert property ($rose(stall) |-> $past(startHit))
    else $error("long write without enabled start");
  chk_stall_length: assert property (s_done |-> stallCnt == PROG_CYCLES)
    else $error("stall length wrong");
  chk_pulse_last: assert property (s_pulse |-> s_last)
    else $error("flash pulse not on last stall cycle");
  chk_one_kind: assert property (!(flashWrite && flashErase))
    else $error("write and erase together");
  chk_erase_align: assert property (flashErase |-> flashBlock[2:0] == 3'h0)
    else $error("erase block not row aligned");
  chk_finish_pulse: assert property (s_done |-> $past(flashWrite || flashErase))
    else $error("stall ended without flash cycle");
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ns
`include "pfta_regs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  import pfta_pkg::*;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, resetHit, re;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] memWordIn;
  logic [18:0] wrBlk, erBlk;
  logic [20:0] rdAddr;
  logic [63:0] wrDat;
  int          errors = 0, checks = 0, wrCnt = 0, erCnt = 0;
  pfta_if bus ();
  pfta_device #(.PROG_CYCLES(8)) i_pfta_device (.clk(clk), .nrst(nrst), .bus(bus.dev));
  pfta_host i_pfta_host (.clk(clk), .nrst(nrst), .bus(bus.host), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .memWordIn(memWordIn), .resetHit(resetHit));
  pfta_checker #(.PROG_CYCLES(8)) i_pfta_checker (.clk(clk), .nrst(nrst),
    .reqValid(bus.reqValid), .reqOp(bus.reqOp), .reqAddr(bus.reqAddr), .reqData(bus.reqData),
    .reqReady(bus.reqReady), .rspValid(bus.rspValid), .stall(bus.stall),
    .flashWrite(bus.flashWrite), .flashErase(bus.flashErase), .flashBlock(bus.flashBlock),
    .flashBusy(bus.flashBusy), .interrupted(bus.interrupted));
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (bus.reqValid === 1'b1 && bus.reqReady === 1'b1 && bus.reqOp === PFTA_OP_TABLE_READ_OP) begin
      rdAddr = bus.memAddr;
    end
    if (bus.flashWrite === 1'b1) begin
      wrCnt++;
      wrBlk = bus.flashBlock;
      wrDat = bus.flashData;
    end
    if (bus.flashErase === 1'b1) begin
      erCnt++;
      erBlk = bus.flashBlock;
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic fail();
    errors++;
    results();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail();
    rd = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic [1:0] o, input logic [1:0] m, input logic [2:0] a,
                    input logic [7:0] d);
    apb(1'b1, `PFTA_APB_WDATA, {24'h0, d});
    apb(1'b1, `PFTA_APB_CMD, {25'h0, a, m, o});
    for (int n = 0; n < 40; n++) begin
      apb(1'b0, `PFTA_APB_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (rd[0] !== 1'b0) fail();
    if (o == 2'h1 || o == 2'h2) apb(1'b0, `PFTA_APB_RDATA, 32'h0);
  endtask
  task automatic setp(input logic [21:0] p);
    op(2'h0, 2'h0, 3'h1, p[7:0]);
    op(2'h0, 2'h0, 3'h2, p[15:8]);
    op(2'h0, 2'h0, 3'h3, {2'b0, p[21:16]});
  endtask
  task automatic chkp(input logic [21:0] p);
    logic [23:0] e;
    e = {2'b0, p};
    for (int i = 0; i < 3; i++) begin
      op(2'h1, 2'h0, 3'(i + 1), 8'h0);
      `CHK(rd[7:0], e[8*i +: 8])
    end
  endtask
  task automatic launch(input logic [7:0] c);
    op(2'h0, 2'h0, 3'h5, `PFTA_UNLOCK_1);
    op(2'h0, 2'h0, 3'h5, `PFTA_UNLOCK_2);
    op(2'h0, 2'h0, 3'h4, c);
  endtask
  task automatic settle();
    for (int n = 0; bus.stall !== 1'b0; n++) begin
      if (n > 100) fail();
      @(posedge clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    op(2'h0, 2'h0, 3'h0, 8'h96);
    op(2'h1, 2'h0, 3'h0, 8'h0);
    `CHK(rd[7:0], 8'h96)
    setp(22'h2a5c3e);
    chkp(22'h2a5c3e);
    apb(1'b0, 12'h010, 32'h0);
    `CHK(re, 1'b1)
    $display("test regs done");
  endtask
  task automatic t_modes();
    logic [21:0] p, e;
    memWordIn <= 16'hb47e;
    for (int m = 0; m < 4; m++) begin
      setp(22'h3fffff);
      op(2'h2, 2'(m), 3'h0, 8'h0);
      p = (m == 3) ? 22'h200000 : 22'h3fffff;
      e = (m == 1 || m == 3) ? 22'h200000 : (m == 2 ? 22'h3ffffe : 22'h3fffff);
      `CHK(rdAddr, p[21:1])
      op(2'h1, 2'h0, 3'h0, 8'h0);
      `CHK(rd[7:0], p[0] ? 8'hb4 : 8'h7e)
      chkp(e);
    end
    $display("test modes done");
  endtask
  task automatic t_prog();
    setp(22'h012347);
    for (int i = 0; i < 8; i++) begin
      op(2'h0, 2'h0, 3'h0, 8'h10 + 8'(i));
      op(2'h3, 2'h3, 3'h0, 8'h0);
    end
    `CHK(wrCnt, 0)
    launch(8'h86);
    settle();
    `CHK(wrCnt, 1)
    `CHK(wrBlk, 19'h2469)
    `CHK(wrDat, 64'h1716151413121110)
    op(2'h1, 2'h0, 3'h4, 8'h0);
    `CHK(rd[7:0], 8'h84)
    launch(8'h96);
    settle();
    `CHK(erCnt, 1)
    `CHK(erBlk, 19'h2468)
    op(2'h1, 2'h0, 3'h4, 8'h0);
    `CHK(rd[7:0], 8'h84)
    $display("test program erase done");
  endtask
  task automatic t_refuse();
    op(2'h0, 2'h0, 3'h5, `PFTA_UNLOCK_1);
    op(2'h1, 2'h0, 3'h0, 8'h0);
    op(2'h0, 2'h0, 3'h5, `PFTA_UNLOCK_2);
    op(2'h0, 2'h0, 3'h4, 8'h86);
    `CHK(bus.stall, 1'b0)
    launch(8'h82);
    `CHK(bus.stall, 1'b0)
    `CHK(wrCnt + erCnt, 2)
    launch(8'h86);
    resetHit <= 1'b1;
    @(posedge clk);
    resetHit <= 1'b0;
    settle();
    `CHK(wrCnt, 1)
    op(2'h1, 2'h0, 3'h4, 8'h0);
    `CHK({rd[3], rd[1]}, 2'b10)
    $display("test refuse abort done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    memWordIn = 16'h0;
    resetHit = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_modes();
    t_prog();
    t_refuse();
    results();
  end
endmodule
